// >>> src/pdm_pkg.sv
// package of constants for the pin drive mode port
package pdm_pkg;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned NUM_USB  = 2;
  // drive mode codes
  localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
  localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
  localparam logic [2:0] DM_RES_UP     = 3'h2;
  localparam logic [2:0] DM_RES_DOWN   = 3'h3;
  localparam logic [2:0] DM_OD_LOW     = 3'h4;
  localparam logic [2:0] DM_OD_HIGH    = 3'h5;
  localparam logic [2:0] DM_STRONG     = 3'h6;
  localparam logic [2:0] DM_RES_BOTH   = 3'h7;
  // interrupt edge select codes
  localparam logic [1:0] IRQ_NONE    = 2'h0;
  localparam logic [1:0] IRQ_RISING  = 2'h1;
  localparam logic [1:0] IRQ_FALLING = 2'h2;
  localparam logic [1:0] IRQ_BOTH    = 2'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_USB  = 2'h0;
endpackage

// >>> src/pdm_port.sv
// pin drive mode port: drive modes, read-back, edge interrupts, usb-capable pins
// ==========================================================================
// Behaviour
// R1: each pin independently takes one of eight drive modes
// R2: three port-wide registers hold one mode bit per pin
// R3: modes 0 and 1 leave the pad undriven
// R4: mode 2 resistive high/strong low, 3 strong high/resistive low, 7 resistive both
// R5: mode 4 high impedance for 1, strong low for 0
// R6: mode 5 strong high for 1, high impedance for 0
// R7: mode 6 drives strongly to the data level
// R8: resistive modes unavailable on special pin in regulated output mode
// R9: pad output from routed signal when hardware output selected, else data register
// R10: sampled pad level updates read-back and feeds digital system when enabled
// R11: separate read-back and output data registers
// R12: config reachable port-wide or per pin
// R13: post-reset port configuration is user programmable
// R14: each pin interrupts on rising, falling or both edges
// R15: each port has its own interrupt request line
// R16: pin interrupt logic detects edges only
// R17: usb pins use drive and pull-up bits; both 0 open drain, drive 1 strong
// R18: usb pin pull-up 1 drive 0 gives resistive high, strong low
// R19: in usb mode drive and pull-up bits have no effect
// R20: port-wide writes never change usb pin drive bits
// R21: after reset pins are high impedance analog
// R22: bidirectional pins switch between hiz digital and selected mode
// R23: each configured edge sets status bit and requests interrupt
// R24: per pin output value, enable, pull-up and pull-down enables to pad
`timescale 1ns/1ps
module pdm_port #(
  parameter logic [7:0] P_RST_DM2 = pdm_pkg::RST_BYTE,
  parameter logic [7:0] P_RST_DM1 = pdm_pkg::RST_BYTE,
  parameter logic [7:0] P_RST_DM0 = pdm_pkg::RST_BYTE,
  parameter logic [7:0] P_RST_DR  = pdm_pkg::RST_BYTE
) (
  input  wire  logic        i_clk_sys,
  input  wire  logic        i_rst_b,
  // port-wide writes
  input  wire  logic        i_port_wr_dm2,
  input  wire  logic        i_port_wr_dm1,
  input  wire  logic        i_port_wr_dm0,
  input  wire  logic        i_port_wr_dr,
  input  wire  logic        i_port_wr_byp,
  input  wire  logic        i_port_wr_bie,
  input  wire  logic        i_port_wr_dinen,
  input  wire  logic [7:0]  i_port_wdata,
  // per-pin writes
  input  wire  logic        i_pin_wr,
  input  wire  logic [2:0]  i_pin_sel,
  input  wire  logic [7:0]  i_pin_wdata,
  // interrupt config and clear
  input  wire  logic        i_irq_cfg_wr,
  input  wire  logic [15:0] i_irq_type,
  input  wire  logic        i_irq_stat_rd,
  // special pin regulated mode per pin
  input  wire  logic [7:0]  i_reg_out_mode,
  // digital system
  input  wire  logic [7:0]  i_dsi_out,
  input  wire  logic [7:0]  i_dsi_oe,
  // usb-capable pins
  input  wire  logic        i_usb_wr,
  input  wire  logic [1:0]  i_usb_drive,
  input  wire  logic [1:0]  i_usb_pullup,
  input  wire  logic [1:0]  i_usb_dr,
  input  wire  logic        i_usb_mode,
  input  wire  logic [1:0]  i_usb_core_out,
  input  wire  logic [1:0]  i_usb_core_oe,
  input  wire  logic [1:0]  i_usb_pad_in,
  // pads
  input  wire  logic [7:0]  i_pad_in,
  output logic [7:0]        o_pad_out,
  output logic [7:0]        o_pad_oe,
  output logic [7:0]        o_pad_pu,
  output logic [7:0]        o_pad_pd,
  output logic [7:0]        o_pad_ibuf_en,
  output logic [1:0]        o_usb_pad_out,
  output logic [1:0]        o_usb_pad_oe,
  output logic [1:0]        o_usb_pad_pu,
  // read-back and status
  output logic [7:0]        o_pin_level_readback,
  output logic [7:0]        o_output_value_reg,
  output logic [7:0]        o_dsi_in,
  output logic [7:0]        o_irq_status,
  output logic              o_port_irq,
  output logic [1:0]        o_usb_level_readback,
  output logic [7:0]        o_pin_cfg_readback
);

  // ========================================================================
  // configuration registers
  logic [7:0]  drive_mode_bit_two_r, drive_mode_bit_two_nxt;
  logic [7:0]  drive_mode_bit_one_r, drive_mode_bit_one_nxt;
  logic [7:0]  drive_mode_bit_zero_r, drive_mode_bit_zero_nxt;
  logic [7:0]  output_value_reg_r, output_value_reg_nxt;
  logic [7:0]  hardware_output_select_r, hardware_output_select_nxt;
  logic [7:0]  bidir_enable_r, bidir_enable_nxt;
  logic [7:0]  din_en_r, din_en_nxt;
  logic [15:0] irq_type_r, irq_type_nxt;
  logic [1:0]  usb_pin_drive_bit_r, usb_pin_drive_bit_nxt;
  logic [1:0]  usb_pin_pullup_bit_r, usb_pin_pullup_bit_nxt;
  logic [1:0]  usb_pin_output_value_r, usb_pin_output_value_nxt;

  always_comb begin
    drive_mode_bit_two_nxt     = drive_mode_bit_two_r;
    drive_mode_bit_one_nxt     = drive_mode_bit_one_r;
    drive_mode_bit_zero_nxt    = drive_mode_bit_zero_r;
    output_value_reg_nxt       = output_value_reg_r;
    hardware_output_select_nxt = hardware_output_select_r;
    bidir_enable_nxt           = bidir_enable_r;
    din_en_nxt                 = din_en_r;
    irq_type_nxt               = irq_type_r;
    usb_pin_drive_bit_nxt      = usb_pin_drive_bit_r;
    usb_pin_pullup_bit_nxt     = usb_pin_pullup_bit_r;
    usb_pin_output_value_nxt   = usb_pin_output_value_r;
    if (i_port_wr_dm2) drive_mode_bit_two_nxt = i_port_wdata;            // [R2] [R12]
    if (i_port_wr_dm1) drive_mode_bit_one_nxt = i_port_wdata;            // [R2]
    if (i_port_wr_dm0) drive_mode_bit_zero_nxt = i_port_wdata;           // [R2]
    if (i_port_wr_dr) output_value_reg_nxt = i_port_wdata;
    if (i_port_wr_byp) hardware_output_select_nxt = i_port_wdata;
    if (i_port_wr_bie) bidir_enable_nxt = i_port_wdata;
    if (i_port_wr_dinen) din_en_nxt = i_port_wdata;
    // per-pin form: [0]=dr [1]=dm0 [2]=dm1 [3]=dm2 [4]=byp [5]=bie [6]=din_en
    if (i_pin_wr) begin                                                  // [R12] [R1]
      output_value_reg_nxt[i_pin_sel]       = i_pin_wdata[0];
      drive_mode_bit_zero_nxt[i_pin_sel]    = i_pin_wdata[1];
      drive_mode_bit_one_nxt[i_pin_sel]     = i_pin_wdata[2];
      drive_mode_bit_two_nxt[i_pin_sel]     = i_pin_wdata[3];
      hardware_output_select_nxt[i_pin_sel] = i_pin_wdata[4];
      bidir_enable_nxt[i_pin_sel]           = i_pin_wdata[5];
      din_en_nxt[i_pin_sel]                 = i_pin_wdata[6];
    end
    if (i_irq_cfg_wr) irq_type_nxt = i_irq_type;                         // [R14]
    // usb bits only through their own controls
    if (i_usb_wr) begin                                                  // [R20]
      usb_pin_drive_bit_nxt    = i_usb_drive;
      usb_pin_pullup_bit_nxt   = i_usb_pullup;
      usb_pin_output_value_nxt = i_usb_dr;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_mode_bit_two_r     <= P_RST_DM2;                             // [R13] [R21]
      drive_mode_bit_one_r     <= P_RST_DM1;
      drive_mode_bit_zero_r    <= P_RST_DM0;
      output_value_reg_r       <= P_RST_DR;
      hardware_output_select_r <= pdm_pkg::RST_BYTE;
      bidir_enable_r           <= pdm_pkg::RST_BYTE;
      din_en_r                 <= pdm_pkg::RST_BYTE;
      irq_type_r               <= 16'h0000;
      usb_pin_drive_bit_r      <= pdm_pkg::RST_USB;
      usb_pin_pullup_bit_r     <= pdm_pkg::RST_USB;
      usb_pin_output_value_r   <= pdm_pkg::RST_USB;
    end else begin
      drive_mode_bit_two_r     <= drive_mode_bit_two_nxt;
      drive_mode_bit_one_r     <= drive_mode_bit_one_nxt;
      drive_mode_bit_zero_r    <= drive_mode_bit_zero_nxt;
      output_value_reg_r       <= output_value_reg_nxt;
      hardware_output_select_r <= hardware_output_select_nxt;
      bidir_enable_r           <= bidir_enable_nxt;
      din_en_r                 <= din_en_nxt;
      irq_type_r               <= irq_type_nxt;
      usb_pin_drive_bit_r      <= usb_pin_drive_bit_nxt;
      usb_pin_pullup_bit_r     <= usb_pin_pullup_bit_nxt;
      usb_pin_output_value_r   <= usb_pin_output_value_nxt;
    end
  end

  // ========================================================================
  // input synchronisers
  logic [7:0] pad_meta_r, pad_sync_r, pad_prev_r;
  logic [1:0] usb_meta_r, usb_sync_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pad_meta_r <= 8'h00;
      pad_sync_r <= 8'h00;
      pad_prev_r <= 8'h00;
      usb_meta_r <= 2'h0;
      usb_sync_r <= 2'h0;
    end else begin
      pad_meta_r <= i_pad_in;
      pad_sync_r <= pad_meta_r;
      pad_prev_r <= pad_sync_r;
      usb_meta_r <= i_usb_pad_in;
      usb_sync_r <= usb_meta_r;
    end
  end

  // ========================================================================
  // drive decode: {oe, out, pu, pd}
  function automatic logic [3:0] pdm_decode(input logic [2:0] dm, input logic d, input logic reg_mode);
    logic [3:0] r;
    r = 4'h0;
    case (dm)
      pdm_pkg::DM_HIZ_ANALOG,
      pdm_pkg::DM_HIZ_DIGITAL: r = 4'h0;                                 // [R3]
      pdm_pkg::DM_RES_UP:   r = d ? 4'h2 : 4'h8;                         // [R4]
      pdm_pkg::DM_RES_DOWN: r = d ? 4'hc : 4'h1;                         // [R4]
      pdm_pkg::DM_OD_LOW:   r = d ? 4'h0 : 4'h8;                         // [R5]
      pdm_pkg::DM_OD_HIGH:  r = d ? 4'hc : 4'h0;                         // [R6]
      pdm_pkg::DM_STRONG:   r = d ? 4'hc : 4'h8;                         // [R7]
      pdm_pkg::DM_RES_BOTH: r = d ? 4'h2 : 4'h1;                         // [R4]
      default:              r = 4'h0;
    endcase
    // regulated special pin: resistive legs replaced by strong drive
    if (reg_mode && (r[1] || r[0])) r = {1'b1, d, 2'b00};               // [R8]
    return r;
  endfunction

  logic [7:0] pad_out_nxt, pad_oe_nxt, pad_pu_nxt, pad_pd_nxt, ibuf_nxt;
  always_comb begin
    logic [2:0] dm;
    logic       d;
    logic [3:0] r;
    dm = 3'h0;
    d  = 1'b0;
    r  = 4'h0;
    for (int i = 0; i < 8; i++) begin
      dm = {drive_mode_bit_two_r[i], drive_mode_bit_one_r[i], drive_mode_bit_zero_r[i]};  // [R1]
      d  = hardware_output_select_r[i] ? i_dsi_out[i] : output_value_reg_r[i];            // [R9]
      if (bidir_enable_r[i] && !i_dsi_oe[i]) dm = pdm_pkg::DM_HIZ_DIGITAL;               // [R22]
      r = pdm_decode(dm, d, i_reg_out_mode[i]);
      pad_oe_nxt[i]  = r[3];                                             // [R24]
      pad_out_nxt[i] = r[2];
      pad_pu_nxt[i]  = r[1];
      pad_pd_nxt[i]  = r[0];
      ibuf_nxt[i]    = (dm != pdm_pkg::DM_HIZ_ANALOG);                   // [R21]
    end
  end

  // usb pads
  logic [1:0] usb_out_nxt, usb_oe_nxt, usb_pu_nxt;
  always_comb begin
    for (int j = 0; j < 2; j++) begin
      if (i_usb_mode) begin                                              // [R19]
        usb_out_nxt[j] = i_usb_core_out[j];
        usb_oe_nxt[j]  = i_usb_core_oe[j];
        usb_pu_nxt[j]  = 1'b0;
      end else if (usb_pin_drive_bit_r[j]) begin                         // [R17]
        usb_out_nxt[j] = usb_pin_output_value_r[j];
        usb_oe_nxt[j]  = 1'b1;
        usb_pu_nxt[j]  = 1'b0;
      end else begin                                                     // [R17] [R18]
        usb_out_nxt[j] = 1'b0;
        usb_oe_nxt[j]  = !usb_pin_output_value_r[j];
        usb_pu_nxt[j]  = usb_pin_pullup_bit_r[j] & usb_pin_output_value_r[j];
      end
    end
  end

  // ========================================================================
  // edge interrupts
  logic [7:0] irq_stat_r, irq_stat_nxt, edge_hit;
  logic       irq_r, irq_nxt;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      case (irq_type_r[2*k +: 2])                                        // [R14] [R16]
        pdm_pkg::IRQ_RISING:  edge_hit[k] = pad_sync_r[k] & ~pad_prev_r[k];
        pdm_pkg::IRQ_FALLING: edge_hit[k] = ~pad_sync_r[k] & pad_prev_r[k];
        pdm_pkg::IRQ_BOTH:    edge_hit[k] = pad_sync_r[k] ^ pad_prev_r[k];
        default:              edge_hit[k] = 1'b0;
      endcase
    end
    // read clears; new edge wins
    irq_stat_nxt = (i_irq_stat_rd ? 8'h00 : irq_stat_r) | edge_hit;      // [R23]
    irq_nxt      = |irq_stat_nxt;                                        // [R15]
  end

  // ========================================================================
  // output registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad_out            <= 8'h00;
      o_pad_oe             <= 8'h00;
      o_pad_pu             <= 8'h00;
      o_pad_pd             <= 8'h00;
      o_pad_ibuf_en        <= 8'h00;
      o_usb_pad_out        <= 2'h0;
      o_usb_pad_oe         <= 2'h0;
      o_usb_pad_pu         <= 2'h0;
      o_pin_level_readback <= 8'h00;
      o_output_value_reg   <= 8'h00;
      o_dsi_in             <= 8'h00;
      o_usb_level_readback <= 2'h0;
      o_pin_cfg_readback   <= 8'h00;
      irq_stat_r           <= 8'h00;
      irq_r                <= 1'b0;
    end else begin
      o_pad_out            <= pad_out_nxt;
      o_pad_oe             <= pad_oe_nxt;
      o_pad_pu             <= pad_pu_nxt;
      o_pad_pd             <= pad_pd_nxt;
      o_pad_ibuf_en        <= ibuf_nxt;
      o_usb_pad_out        <= usb_out_nxt;
      o_usb_pad_oe         <= usb_oe_nxt;
      o_usb_pad_pu         <= usb_pu_nxt;
      o_pin_level_readback <= pad_sync_r;                                // [R10] [R11]
      o_output_value_reg   <= output_value_reg_r;                        // [R11]
      o_dsi_in             <= pad_sync_r & din_en_r;                     // [R10]
      o_usb_level_readback <= usb_sync_r;
      o_pin_cfg_readback   <= {1'b0, din_en_r[i_pin_sel], bidir_enable_r[i_pin_sel],
                               hardware_output_select_r[i_pin_sel], drive_mode_bit_two_r[i_pin_sel],
                               drive_mode_bit_one_r[i_pin_sel], drive_mode_bit_zero_r[i_pin_sel],
                               output_value_reg_r[i_pin_sel]};           // [R12]
      irq_stat_r           <= irq_stat_nxt;
      irq_r                <= irq_nxt;
    end
  end

  assign o_irq_status = irq_stat_r;
  assign o_port_irq   = irq_r;

endmodule // pdm_port

// >>> testbench/pdm_pin_world.sv
// external circuitry on the pins
`timescale 1ns/1ps
module pdm_pin_world #(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_pu,
  input  wire logic [W-1:0] i_pd,
  input  wire logic [W-1:0] i_ext,
  input  wire logic [W-1:0] i_ext_en,
  output logic      [W-1:0] o_level
);
  // ==========================================================================
  // floating pins wander every cycle
  logic [W-1:0] float_r = '0;
  always_ff @(posedge i_clk_sys) float_r <= ~float_r;
  always_comb begin
    for (int n = 0; n < W; n++) begin
      o_level[n] = i_oe[n] ? i_out[n] : i_ext_en[n] ? i_ext[n] : i_pu[n] ? 1'b1 : i_pd[n] ? 1'b0 : float_r[n];
    end
  end
endmodule // pdm_pin_world

// >>> testbench/pdm_port_properties.sv
// concurrent checks for the pin drive mode port
`timescale 1ns/1ps
module pdm_port_properties (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic       i_port_wr_dr,
  input wire logic       i_pin_wr,
  input wire logic [7:0] i_port_wdata,
  input wire logic       i_irq_stat_rd,
  input wire logic [7:0] i_pad_in,
  input wire logic       i_usb_wr,
  input wire logic       i_usb_mode,
  input wire logic [1:0] i_usb_core_out,
  input wire logic [1:0] i_usb_core_oe,
  input wire logic [7:0] o_pad_oe,
  input wire logic [7:0] o_pad_pu,
  input wire logic [7:0] o_pad_pd,
  input wire logic [7:0] o_pin_level_readback,
  input wire logic [7:0] o_output_value_reg,
  input wire logic [7:0] o_dsi_in,
  input wire logic [7:0] o_irq_status,
  input wire logic       o_port_irq,
  input wire logic [1:0] o_usb_pad_out,
  input wire logic [1:0] o_usb_pad_oe,
  input wire logic [1:0] o_usb_pad_pu
);
  // ==========================================================================
  // sequences
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_pad_steady; $stable(i_pad_in) [*4]; endsequence
  sequence s_core_steady; (i_usb_mode && $stable(i_usb_core_oe) && $stable(i_usb_core_out)) [*3]; endsequence
  sequence s_usb_quiet; (!i_usb_wr && !i_usb_mode) [*4]; endsequence
  sequence s_dr_wr; i_port_wr_dr && !i_pin_wr ##1 !i_port_wr_dr && !i_pin_wr; endsequence
  // ==========================================================================
  // assertions
  AST_RST_HIZ: assert property ($rose(i_rst_b) |-> o_pad_oe == 8'h00 && o_pad_pu == 8'h00)
    else $error("pads not idle after reset");
  AST_LEGS: assert property (((o_pad_pu & o_pad_pd) | (o_pad_oe & (o_pad_pu | o_pad_pd))) == 8'h00)
    else $error("pad legs overlap");
  AST_IRQ_LINE: assert property (o_port_irq == (|o_irq_status))
    else $error("port irq differs from status");
  AST_STICKY: assert property (!i_irq_stat_rd |=> (o_irq_status & $past(o_irq_status)) == $past(o_irq_status))
    else $error("status bit lost without clear");
  AST_READBACK: assert property (s_pad_steady |-> o_pin_level_readback == i_pad_in)
    else $error("readback not pad level");
  AST_DSI_IN: assert property ((o_dsi_in & ~o_pin_level_readback) == 8'h00)
    else $error("digital input not from pad");
  AST_USB_MODE: assert property (s_core_steady |-> o_usb_pad_oe == i_usb_core_oe &&
    (o_usb_pad_out & i_usb_core_oe) == (i_usb_core_out & i_usb_core_oe)) else $error("usb pads ignore core");
  AST_USB_QUIET: assert property (s_usb_quiet |-> $stable(o_usb_pad_oe) && $stable(o_usb_pad_pu))
    else $error("usb pads changed without usb write");
  AST_ODR: assert property (s_dr_wr |=> o_output_value_reg == $past(i_port_wdata, 2))
    else $error("output value register wrong");
endmodule // pdm_port_properties

// >>> testbench/tb_top.sv
// testbench top for the pin drive mode port
`timescale 1ns/1ps
bind pdm_port pdm_port_properties pdm_port_properties_i (.i_clk_sys, .i_rst_b, .i_port_wr_dr, .i_pin_wr,
  .i_port_wdata, .i_irq_stat_rd, .i_pad_in, .i_usb_wr, .i_usb_mode, .i_usb_core_out, .i_usb_core_oe, .o_pad_oe,
  .o_pad_pu, .o_pad_pd, .o_pin_level_readback, .o_output_value_reg, .o_dsi_in, .o_irq_status, .o_port_irq,
  .o_usb_pad_out, .o_usb_pad_oe, .o_usb_pad_pu);
module tb_top;
  // ==========================================================================
  // signals
  logic i_clk_sys = '0, i_rst_b = '0, i_port_wr_dm2 = '0, i_port_wr_dm1 = '0, i_port_wr_dm0 = '0;
  logic i_port_wr_dr = '0, i_port_wr_byp = '0, i_port_wr_bie = '0, i_port_wr_dinen = '0, i_pin_wr = '0;
  logic i_irq_cfg_wr = '0, i_irq_stat_rd = '0, i_usb_wr = '0, i_usb_mode = '0, o_port_irq;
  logic [2:0] i_pin_sel = '0;
  logic [15:0] i_irq_type = '0;
  logic [7:0] i_port_wdata = '0, i_pin_wdata = '0, i_reg_out_mode = '0, i_dsi_out = '0, i_dsi_oe = '0;
  logic [7:0] ext = '0, ext_en = '0, i_pad_in, o_pad_out, o_pad_oe, o_pad_pu, o_pad_pd, o_pad_ibuf_en;
  logic [7:0] o_pin_level_readback, o_output_value_reg, o_dsi_in, o_irq_status, o_pin_cfg_readback;
  logic [1:0] i_usb_drive = '0, i_usb_pullup = '0, i_usb_dr = '0, i_usb_core_out = '0, i_usb_core_oe = '0;
  logic [1:0] i_usb_pad_in, o_usb_pad_out, o_usb_pad_oe, o_usb_pad_pu, o_usb_level_readback;
  int num_errors = 0, compares = 0, cycles = 0;
  pdm_port pdm_port_i (.i_clk_sys, .i_rst_b, .i_port_wr_dm2, .i_port_wr_dm1, .i_port_wr_dm0, .i_port_wr_dr,
    .i_port_wr_byp, .i_port_wr_bie, .i_port_wr_dinen, .i_port_wdata, .i_pin_wr, .i_pin_sel, .i_pin_wdata,
    .i_irq_cfg_wr, .i_irq_type, .i_irq_stat_rd, .i_reg_out_mode, .i_dsi_out, .i_dsi_oe, .i_usb_wr, .i_usb_drive,
    .i_usb_pullup, .i_usb_dr, .i_usb_mode, .i_usb_core_out, .i_usb_core_oe, .i_usb_pad_in, .i_pad_in, .o_pad_out,
    .o_pad_oe, .o_pad_pu, .o_pad_pd, .o_pad_ibuf_en, .o_usb_pad_out, .o_usb_pad_oe, .o_usb_pad_pu,
    .o_pin_level_readback, .o_output_value_reg, .o_dsi_in, .o_irq_status, .o_port_irq, .o_usb_level_readback,
    .o_pin_cfg_readback);
  pdm_pin_world #(.W(8)) pdm_pin_world_i (.i_clk_sys, .i_oe(o_pad_oe), .i_out(o_pad_out), .i_pu(o_pad_pu),
    .i_pd(o_pad_pd), .i_ext(ext), .i_ext_en(ext_en), .o_level(i_pad_in));
  pdm_pin_world #(.W(2)) usb_world_i (.i_clk_sys, .i_oe(o_usb_pad_oe), .i_out(o_usb_pad_out),
    .i_pu(o_usb_pad_pu), .i_pd(2'h0), .i_ext(2'h0), .i_ext_en(2'h0), .o_level(i_usb_pad_in));
  // second port with a user reset state: all pins mode 1, data 5a
  logic [7:0] user_dr, user_ibuf, usb_seen;
  assign usb_seen = {2'h0, o_usb_pad_oe, o_usb_pad_out & o_usb_pad_oe, o_usb_pad_pu};
  pdm_port #(.P_RST_DM2(8'h00), .P_RST_DM1(8'h00), .P_RST_DM0(8'hff), .P_RST_DR(8'h5a)) pdm_port_user_i (.i_clk_sys,
    .i_rst_b, .i_port_wr_dm2, .i_port_wr_dm1, .i_port_wr_dm0, .i_port_wr_dr, .i_port_wr_byp, .i_port_wr_bie,
    .i_port_wr_dinen, .i_port_wdata, .i_pin_wr, .i_pin_sel, .i_pin_wdata, .i_irq_cfg_wr, .i_irq_type, .i_irq_stat_rd,
    .i_reg_out_mode, .i_dsi_out, .i_dsi_oe, .i_usb_wr, .i_usb_drive, .i_usb_pullup, .i_usb_dr, .i_usb_mode,
    .i_usb_core_out, .i_usb_core_oe, .i_usb_pad_in, .i_pad_in, .o_pad_out(), .o_pad_oe(), .o_pad_pu(), .o_pad_pd(),
    .o_pad_ibuf_en(user_ibuf), .o_usb_pad_out(), .o_usb_pad_oe(), .o_usb_pad_pu(), .o_pin_level_readback(),
    .o_output_value_reg(user_dr), .o_dsi_in(), .o_irq_status(), .o_port_irq(), .o_usb_level_readback(),
    .o_pin_cfg_readback());
  // ==========================================================================
  // helpers
  always #20 i_clk_sys = ~i_clk_sys;
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    wt(1);
    s = 1'b1;
    wt(1);
    s = 1'b0;
  endtask
  task automatic port_wr(logic [7:0] d2, logic [7:0] d1, logic [7:0] d0, logic [7:0] dr);
    i_port_wdata = d2;
    pulse(i_port_wr_dm2);
    i_port_wdata = d1;
    pulse(i_port_wr_dm1);
    i_port_wdata = d0;
    pulse(i_port_wr_dm0);
    i_port_wdata = dr;
    pulse(i_port_wr_dr);
  endtask
  // {oe, out, pu, pd} of one pin
  function automatic logic [3:0] exp_pin(logic [2:0] m, logic d, logic r);
    case (m)
      3'h2: return d ? (r ? 4'hc : 4'h2) : 4'h8;
      3'h3: return d ? 4'hc : (r ? 4'h8 : 4'h1);
      3'h4: return d ? 4'h0 : 4'h8;
      3'h5: return d ? 4'hc : 4'h0;
      3'h6: return {1'b1, d, 2'h0};
      3'h7: return r ? {1'b1, d, 2'h0} : (d ? 4'h2 : 4'h1);
      default: return 4'h0;
    endcase
  endfunction
  // ==========================================================================
  // scenarios
  task automatic t_modes;
    logic [7:0] d2, d1, d0, eo, ev, ep, ed;
    logic [2:0] m;
    for (int r = 0; r < 2; r++) for (int k = 0; k < 8; k++) for (int d = 0; d < 2; d++) begin
      i_reg_out_mode = r ? 8'hff : 8'h00;
      for (int n = 0; n < 8; n++) begin
        m = 3'(k + n);
        {d2[n], d1[n], d0[n]} = m;
        {eo[n], ev[n], ep[n], ed[n]} = exp_pin(m, d[0], r[0]);
      end
      port_wr(d2, d1, d0, d ? 8'hff : 8'h00);
      wt(3);
      chk("pad_oe", eo, o_pad_oe);
      chk("pad_out", ev, o_pad_out & o_pad_oe);
      chk("pad_pu", ep, o_pad_pu);
      chk("pad_pd", ed, o_pad_pd);
    end
  endtask
  task automatic t_route;
    i_reg_out_mode = 8'h00;
    port_wr(8'hff, 8'hff, 8'h00, 8'h00);
    i_dsi_out = 8'h5a;
    i_dsi_oe = 8'h0f;
    i_port_wdata = 8'hff;
    pulse(i_port_wr_byp);
    pulse(i_port_wr_bie);
    wt(3);
    chk("bidir_oe", 8'h0f, o_pad_oe);
    chk("bypass_out", 8'h0a, o_pad_out & o_pad_oe);
    i_port_wdata = 8'h00;
    pulse(i_port_wr_byp);
    pulse(i_port_wr_bie);
    wt(3);
    chk("reg_out", 8'h00, o_pad_out & o_pad_oe);
  endtask
  task automatic t_read;
    port_wr(8'h00, 8'h00, 8'hff, 8'ha5);
    ext = 8'hc3;
    ext_en = 8'hff;
    i_port_wdata = 8'hff;
    pulse(i_port_wr_dinen);
    wt(4);
    chk("readback", 8'hc3, o_pin_level_readback);
    chk("dsi_in", 8'hc3, o_dsi_in);
    chk("out_value", 8'ha5, o_output_value_reg);
    chk("ibuf_en", 8'hff, o_pad_ibuf_en);
    i_port_wdata = 8'h0f;
    pulse(i_port_wr_dinen);
    wt(3);
    chk("dsi_in_part", 8'h03, o_dsi_in);
  endtask
  task automatic t_irq;
    ext = 8'h00;
    i_irq_type = 16'h0039;
    pulse(i_irq_cfg_wr);
    wt(4);
    pulse(i_irq_stat_rd);
    chk("irq_clear", 8'h00, o_irq_status);
    ext = 8'h0f;
    wt(5);
    chk("irq_rise", 8'h05, o_irq_status);
    chk("irq_line", 8'h01, {7'h0, o_port_irq});
    pulse(i_irq_stat_rd);
    wt(3);
    chk("irq_level", 8'h00, o_irq_status);
    ext = 8'h00;
    wt(5);
    chk("irq_fall", 8'h06, o_irq_status);
    pulse(i_irq_stat_rd);
  endtask
  task automatic t_pin;
    i_pin_sel = 3'h3;
    i_pin_wdata = 8'h0d;
    pulse(i_pin_wr);
    wt(3);
    chk("pin_cfg", 8'h0d, o_pin_cfg_readback);
    chk("pin_oe", 8'h08, o_pad_oe);
    chk("pin_dr", 8'had, o_output_value_reg);
  endtask
  task automatic t_usb;
    logic [2:0] c;
    logic [1:0] eo, ev, ep;
    for (int i = 0; i < 8; i++) begin
      for (int p = 0; p < 2; p++) begin
        c = p ? 3'(7 - i) : 3'(i);
        {i_usb_pullup[p], i_usb_drive[p], i_usb_dr[p]} = c;
        eo[p] = c[1] | ~c[0];
        ev[p] = c[1] & c[0];
        ep[p] = c[2] & ~c[1] & c[0];
      end
      pulse(i_usb_wr);
      wt(3);
      chk("usb_pad", {2'h0, eo, ev, ep}, usb_seen);
    end
    port_wr(8'h00, 8'h00, 8'h00, 8'h00);
    wt(3);
    chk("usb_keep", {2'h0, eo, ev, ep}, usb_seen);
    chk("usb_level", 8'h01, {6'h0, o_usb_level_readback});
    i_usb_core_out = 2'h3;
    i_usb_core_oe = 2'h1;
    i_usb_mode = 1'b1;
    wt(4);
    chk("usb_core", 8'h11, {2'h0, o_usb_pad_oe, 2'h0, o_usb_pad_out & o_usb_pad_oe});
    i_usb_mode = 1'b0;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    wt(4);
    i_rst_b = 1'b1;
    wt(1);
    chk("reset_oe", 8'h00, o_pad_oe | o_pad_pu | o_pad_pd);
    chk("reset_ibuf", 8'h00, o_pad_ibuf_en);
    chk("user_rst_dr", 8'h5a, user_dr);
    chk("user_rst_ibuf", 8'hff, user_ibuf);
    t_modes;
    t_route;
    t_read;
    t_irq;
    t_pin;
    t_usb;
    tally_and_finish;
  end
endmodule // tb_top
